/* File: rtl/aps_supervisor.sv */
// Purpose: auxiliary protection supervisor with Avalon-MM register slave
// Assumes: all inputs synchronous to clk_sys, temperatures in 0.1 C units
// Notes: one wait state on every access; faults latch until fault_reset
`timescale 1ns/10ps
module aps_supervisor
    import aps_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic [13:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    input  wire logic        run_cmd,
    input  wire logic        dc_brake_active,
    input  wire logic        pre_excite_active,
    input  wire logic        out_phase_missing,
    input  wire logic [15:0] in_bus_ripple_pct,
    input  wire logic        out_short_seen,
    input  wire logic        out_short_valid,
    input  wire logic        fan_short_seen,
    input  wire logic        supply_short_seen,
    input  wire logic        sync_machine,
    input  wire logic        rotor_turning,
    input  wire logic [15:0] module_temp,
    input  wire logic [15:0] heatsink_temperature_monitor,
    input  wire logic        fault_reset,
    output logic             out_gnd_test_req,
    output logic             run_enable,
    output logic             coast_stop,
    output logic             fan_on,
    output logic             output_phase_loss_fault,
    output logic             input_phase_loss_warning,
    output logic             input_phase_loss_fault,
    output logic             output_ground_short_fault,
    output logic             fan_ground_short_fault,
    output logic             supply_ground_short_fault,
    output logic             heatsink_overheat_warning,
    output logic             platinum_resistance_sensor
);
    typedef enum logic [3:0] {
        GND_IDLE = 4'b0001,
        GND_TEST = 4'b0010,
        GND_PASS = 4'b0100,
        GND_FAIL = 4'b1000
    } aps_gnd_type;

    function automatic logic [3:0] digit(input logic [15:0] v, input int n);
        digit = v[n*4 +: 4];
    endfunction : digit

    function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] m);
        clamp = (v > {16'h0000, m}) ? m : v[15:0];
    endfunction : clamp

    logic [15:0] phase_sel_r;
    logic [15:0] in_thresh_r;
    logic [15:0] gnd_sel_r;
    logic [15:0] fan_pol_r;
    logic [15:0] fan_delay_r;
    logic [15:0] hs_level_r;
    logic [15:0] sens_sel_r;
    logic [NUM_EV-1:0] irq_stat_r;
    logic [NUM_EV-1:0] irq_en_r;
    logic [NUM_EV-1:0] ev_nxt;
    logic [NUM_EV-1:0] clr_nxt;
    logic [11:0] idx;
    logic        acc_nxt;
    logic        wr_nxt;
    logic [31:0] rd_nxt;
    aps_gnd_type gnd_r;
    logic        run_d_r;
    logic        out_ph_on;
    logic [3:0]  in_mode;
    logic [3:0]  gnd_mode;
    logic [3:0]  pol;
    logic        in_loss;
    logic        hs_hot;
    logic        fan_hot;
    logic        fan_demand;
    logic [15:0] off_limit;
    logic [31:0] tick_cnt_r;
    logic        tick;
    logic [15:0] run_cnt_r;
    logic [15:0] idle_cnt_r;
    logic        start_block;

    // registers are word-wide, so the two low address bits are ignored
    assign idx     = avs_address[13:2];
    assign acc_nxt = (avs_read | avs_write) & avs_waitrequest;
    assign wr_nxt  = avs_write & ~avs_waitrequest;

    always_comb begin
        rd_nxt = 32'h0000_0000;
        case (idx)
            IDX_PHASE_SEL: rd_nxt = {16'h0000, phase_sel_r};
            IDX_IN_THRESH: rd_nxt = {16'h0000, in_thresh_r};
            IDX_GND_SEL:   rd_nxt = {16'h0000, gnd_sel_r};
            IDX_FAN_POL:   rd_nxt = {16'h0000, fan_pol_r};
            IDX_FAN_DELAY: rd_nxt = {16'h0000, fan_delay_r};
            IDX_HS_LEVEL:  rd_nxt = {16'h0000, hs_level_r};
            IDX_SENS_SEL:  rd_nxt = {16'h0000, sens_sel_r};
            IDX_IRQ_STAT:  rd_nxt = {25'h0, irq_stat_r};
            IDX_IRQ_EN:    rd_nxt = {25'h0, irq_en_r};
            IDX_LIVE:      rd_nxt = {22'h0, fan_on, run_enable, coast_stop,
                                     heatsink_overheat_warning, supply_ground_short_fault,
                                     fan_ground_short_fault, output_ground_short_fault,
                                     input_phase_loss_fault, input_phase_loss_warning,
                                     output_phase_loss_fault};
            default:       rd_nxt = 32'h0000_0000;
        endcase
    end

    // the answer comes one cycle after the request is seen
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~acc_nxt;
            if (acc_nxt) begin
                avs_readdata <= rd_nxt;
            end
        end
    end

    // out-of-range writes saturate rather than being refused
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_sel_r <= RST_PHASE_SEL;
            in_thresh_r <= RST_IN_THRESH;
            gnd_sel_r   <= RST_GND_SEL;
            fan_pol_r   <= RST_FAN_POL;
            fan_delay_r <= RST_FAN_DELAY;
            hs_level_r  <= RST_HS_LEVEL;
            sens_sel_r  <= RST_SENS_SEL;
            irq_en_r    <= '0;
        end else if (wr_nxt) begin
            case (idx)
                IDX_PHASE_SEL: phase_sel_r <= avs_writedata[15:0];
                IDX_IN_THRESH: in_thresh_r <= clamp(avs_writedata, MAX_IN_THRESH);
                IDX_GND_SEL:   gnd_sel_r   <= avs_writedata[15:0];
                IDX_FAN_POL:   fan_pol_r   <= avs_writedata[15:0];
                IDX_FAN_DELAY: fan_delay_r <= clamp(avs_writedata, MAX_FAN_DELAY);
                IDX_HS_LEVEL:  hs_level_r  <= clamp(avs_writedata, MAX_HS_LEVEL);
                IDX_SENS_SEL:  sens_sel_r  <= avs_writedata[15:0];
                IDX_IRQ_EN:    irq_en_r    <= avs_writedata[NUM_EV-1:0];
                default:       ;
            endcase
        end
    end

    // decimal fields, one nibble each, lowest first
    assign out_ph_on = (digit(phase_sel_r, 0) == 4'h1)
                     | dc_brake_active | pre_excite_active;
    assign in_mode   = digit(phase_sel_r, 1);
    assign gnd_mode  = digit(gnd_sel_r, 0);
    assign pol       = digit(fan_pol_r, 0);
    assign in_loss   = in_bus_ripple_pct > in_thresh_r;
    assign hs_hot    = heatsink_temperature_monitor > hs_level_r;
    assign fan_hot   = module_temp > FAN_HOT_TEMP;

    // power-up test starts from reset; pre-run test on every start request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gnd_r   <= GND_IDLE;
            run_d_r <= 1'b0;
        end else begin
            run_d_r <= run_cmd;
            case (gnd_r)
                GND_IDLE: begin
                    if (gnd_mode == 4'h1 || (gnd_mode == 4'h2 && run_cmd && !run_d_r)) begin
                        gnd_r <= GND_TEST;
                    end else if (gnd_mode == 4'h0) begin
                        gnd_r <= GND_PASS;
                    end
                end
                GND_TEST: begin
                    if (out_short_valid) begin
                        gnd_r <= out_short_seen ? GND_FAIL : GND_PASS;
                    end
                end
                GND_PASS: begin
                    if (gnd_mode == 4'h2 && !run_cmd) begin
                        gnd_r <= GND_IDLE;
                    end
                end
                GND_FAIL: begin
                    if (fault_reset) begin
                        gnd_r <= GND_IDLE;
                    end
                end
                default: gnd_r <= GND_IDLE;
            endcase
        end
    end

    // once running the rotor turns anyway, so in gnd_mode 2 only a start of a sync_machine whose rotor is turning is refused
    assign start_block = (gnd_mode == 4'h2) & sync_machine & rotor_turning & ~run_enable;

    assign ev_nxt[EV_OUT_PH]   = out_ph_on & out_phase_missing;
    assign ev_nxt[EV_IN_WARN]  = (in_mode == 4'h1) & in_loss;
    assign ev_nxt[EV_IN_FAULT] = (in_mode == 4'h2) & in_loss;
    assign ev_nxt[EV_OUT_GND]  = (gnd_r == GND_TEST) & out_short_valid & out_short_seen;
    assign ev_nxt[EV_FAN_GND]  = (digit(gnd_sel_r, 1) == 4'h1) & fan_short_seen;
    assign ev_nxt[EV_SUP_GND]  = (digit(gnd_sel_r, 2) == 4'h1) & supply_short_seen;
    assign ev_nxt[EV_HS_WARN]  = hs_hot;

    // faults hold until fault_reset; a new event in that cycle still wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            output_phase_loss_fault   <= 1'b0;
            input_phase_loss_fault    <= 1'b0;
            output_ground_short_fault <= 1'b0;
            fan_ground_short_fault    <= 1'b0;
            supply_ground_short_fault <= 1'b0;
        end else begin
            output_phase_loss_fault   <= ev_nxt[EV_OUT_PH]
                                       | (output_phase_loss_fault & ~fault_reset);
            input_phase_loss_fault    <= ev_nxt[EV_IN_FAULT]
                                       | (input_phase_loss_fault & ~fault_reset);
            output_ground_short_fault <= ev_nxt[EV_OUT_GND]
                                       | (output_ground_short_fault & ~fault_reset);
            fan_ground_short_fault    <= ev_nxt[EV_FAN_GND]
                                       | (fan_ground_short_fault & ~fault_reset);
            supply_ground_short_fault <= ev_nxt[EV_SUP_GND]
                                       | (supply_ground_short_fault & ~fault_reset);
        end
    end

    // warnings follow their condition, running is not affected
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            input_phase_loss_warning  <= 1'b0;
            heatsink_overheat_warning <= 1'b0;
            platinum_resistance_sensor <= 1'b0;
            out_gnd_test_req          <= 1'b0;
        end else begin
            input_phase_loss_warning  <= ev_nxt[EV_IN_WARN];
            heatsink_overheat_warning <= hs_hot;
            platinum_resistance_sensor <= digit(sens_sel_r, 0) == 4'h0;
            out_gnd_test_req          <= gnd_r == GND_TEST;
        end
    end

    // any fault coasts the motor; warnings never do
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            coast_stop <= 1'b0;
            run_enable <= 1'b0;
        end else begin
            coast_stop <= output_phase_loss_fault | input_phase_loss_fault
                        | output_ground_short_fault
                        | fan_ground_short_fault | supply_ground_short_fault;
            run_enable <= run_cmd & (gnd_r == GND_PASS) & ~coast_stop
                        & ~start_block;
        end
    end

    // 10 ms time base keeps the fan counters narrow
    assign tick = tick_cnt_r == 32'(TICK_LEN - 1);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tick_cnt_r <= 32'h0000_0000;
        end else begin
            tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst || !run_cmd) begin
            run_cnt_r <= 16'h0000;
        end else if (tick && run_cnt_r < RUN_ON_TICKS) begin
            run_cnt_r <= run_cnt_r + 16'h0001;
        end
    end

    always_comb begin
        fan_demand = 1'b0;
        off_limit  = fan_delay_r;
        case (pol)
            4'h0: fan_demand = 1'b1;
            4'h1: begin
                off_limit  = STOP_OFF_TICKS;
                fan_demand = run_cmd ? (run_cnt_r >= RUN_ON_TICKS) : fan_hot;
            end
            4'h2: fan_demand = run_cmd & fan_hot;
            default: fan_demand = 1'b1;
        endcase
    end

    // fan lingers for the off delay after its demand goes away
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            fan_on     <= 1'b1;
            idle_cnt_r <= 16'h0000;
        end else if (fan_demand) begin
            fan_on     <= 1'b1;
            idle_cnt_r <= 16'h0000;
        end else if (fan_on) begin
            if (idle_cnt_r >= off_limit) begin
                fan_on <= 1'b0;
            end else if (tick) begin
                idle_cnt_r <= idle_cnt_r + 16'h0001;
            end
        end else begin
            idle_cnt_r <= 16'h0000;
        end
    end

    // status: set wins over a clear in the same cycle
    assign clr_nxt = (wr_nxt && idx == IDX_IRQ_CLR) ? avs_writedata[NUM_EV-1:0] : '0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_stat_r <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_r <= ev_nxt | (irq_stat_r & ~clr_nxt);
            irq <= |((ev_nxt | (irq_stat_r & ~clr_nxt)) & irq_en_r);
        end
    end

    property p_out_phase;
        @(posedge clk_sys) disable iff (srst)
        (out_phase_missing && digit(phase_sel_r, 0) == 4'h1)
            |=> output_phase_loss_fault ##1 coast_stop;
    endproperty
    a_out_phase: assert property (p_out_phase) else $error("output phase loss not faulted");

    property p_brake_phase;
        @(posedge clk_sys) disable iff (srst)
        (out_phase_missing && dc_brake_active) |=> output_phase_loss_fault;
    endproperty
    a_brake_phase: assert property (p_brake_phase) else $error("phase check off in braking");

    property p_in_warn;
        @(posedge clk_sys) disable iff (srst)
        (in_mode == 4'h1 && in_loss) |=> input_phase_loss_warning && !$rose(input_phase_loss_fault);
    endproperty
    a_in_warn: assert property (p_in_warn) else $error("input warn wrong");

    property p_in_off;
        @(posedge clk_sys) disable iff (srst)
        (in_mode == 4'h0) |=> !input_phase_loss_warning;
    endproperty
    a_in_off: assert property (p_in_off) else $error("input check not disabled");

    property p_thresh_max;
        @(posedge clk_sys) disable iff (srst)
        in_thresh_r <= MAX_IN_THRESH && fan_delay_r <= MAX_FAN_DELAY && hs_level_r <= MAX_HS_LEVEL;
    endproperty
    a_thresh_max: assert property (p_thresh_max) else $error("setting above range");

    property p_fan_gnd;
        @(posedge clk_sys) disable iff (srst)
        (digit(gnd_sel_r, 1) == 4'h0 && !fan_ground_short_fault)
            |=> !$rose(fan_ground_short_fault);
    endproperty
    a_fan_gnd: assert property (p_fan_gnd) else $error("fan check not skipped");

    property p_rot_block;
        @(posedge clk_sys) disable iff (srst)
        (gnd_mode == 4'h2 && sync_machine && rotor_turning && !run_enable) |=> !run_enable;
    endproperty
    a_rot_block: assert property (p_rot_block) else $error("rotating machine started");

    property p_pol0;
        @(posedge clk_sys) disable iff (srst)
        (pol == 4'h0) |=> fan_on;
    endproperty
    a_pol0: assert property (p_pol0) else $error("fan off in policy 0");

    property p_hs;
        @(posedge clk_sys) disable iff (srst)
        hs_hot |=> heatsink_overheat_warning;
    endproperty
    a_hs: assert property (p_hs) else $error("heatsink warning missing");

    property p_irq_set;
        @(posedge clk_sys) disable iff (srst)
        (|ev_nxt) |=> (irq_stat_r & $past(ev_nxt)) == $past(ev_nxt);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event lost from status");
endmodule : aps_supervisor

/* File: rtl/aps_pkg.sv */
// Purpose: constants for the auxiliary protection supervisor
// Assumes: 10 MHz clk_sys, registers one word each, byte address = 4 * index
// Notes: parameter fields hold one decimal option per nibble
package aps_pkg;
    localparam logic [11:0] IDX_PHASE_SEL  = 12'ha14;
    localparam logic [11:0] IDX_IN_THRESH  = 12'ha15;
    localparam logic [11:0] IDX_GND_SEL    = 12'ha16;
    localparam logic [11:0] IDX_FAN_POL    = 12'ha17;
    localparam logic [11:0] IDX_FAN_DELAY  = 12'ha18;
    localparam logic [11:0] IDX_HS_LEVEL   = 12'ha19;
    localparam logic [11:0] IDX_SENS_SEL   = 12'ha1a;
    localparam logic [11:0] IDX_IRQ_STAT   = 12'ha30;
    localparam logic [11:0] IDX_IRQ_CLR    = 12'ha31;
    localparam logic [11:0] IDX_IRQ_EN     = 12'ha32;
    localparam logic [11:0] IDX_LIVE       = 12'ha33;
    localparam logic [15:0] RST_PHASE_SEL  = 16'h0021;
    localparam logic [15:0] RST_IN_THRESH  = 16'h0064;
    localparam logic [15:0] MAX_IN_THRESH  = 16'h012c;
    localparam logic [15:0] RST_GND_SEL    = 16'h0111;
    localparam logic [15:0] RST_FAN_POL    = 16'h0001;
    localparam logic [15:0] RST_FAN_DELAY  = 16'h0bb8;
    localparam logic [15:0] MAX_FAN_DELAY  = 16'h1770;
    localparam logic [15:0] RST_HS_LEVEL   = 16'h0320;
    localparam logic [15:0] MAX_HS_LEVEL   = 16'h03e8;
    localparam logic [15:0] RST_SENS_SEL   = 16'h0001;
    localparam logic [15:0] FAN_HOT_TEMP   = 16'h01f4;
    localparam int          TICK_MS        = 10;
    localparam int          CLK_KHZ        = 10000;
    localparam int          TICK_CYCLES    = TICK_MS * CLK_KHZ;
    localparam int          RUN_ON_MS      = 1000;
    localparam int          STOP_OFF_MS    = 30000;
    localparam logic [15:0] RUN_ON_TICKS   = 16'(RUN_ON_MS / TICK_MS);
    localparam logic [15:0] STOP_OFF_TICKS = 16'(STOP_OFF_MS / TICK_MS);
    localparam int          EV_OUT_PH      = 0;
    localparam int          EV_IN_WARN     = 1;
    localparam int          EV_IN_FAULT    = 2;
    localparam int          EV_OUT_GND     = 3;
    localparam int          EV_FAN_GND     = 4;
    localparam int          EV_SUP_GND     = 5;
    localparam int          EV_HS_WARN     = 6;
    localparam int          NUM_EV         = 7;
endpackage : aps_pkg

/* File: dv/aps_power_stage.sv */
// Purpose: power stage model answering the output ground test
// Assumes: test request is a level from the supervisor, one clock
// Notes: result line toggles outside the answer so a stale value never passes
`timescale 1ns/10ps
module aps_power_stage (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic out_gnd_test_req,
    input  wire logic short_fail,
    input  wire logic slow,
    output logic      out_short_valid,
    output logic      out_short_seen
);
    logic [4:0] wait_r;
    logic       hit;

    assign hit = (wait_r == (slow ? 5'h14 : 5'h03));

    always_ff @(posedge clk_sys) begin
        if (srst || !out_gnd_test_req) begin
            wait_r          <= 5'h00;
            out_short_valid <= 1'b0;
        end else begin
            wait_r          <= wait_r + 5'h01;
            out_short_valid <= hit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst)
            out_short_seen <= 1'b0;
        else
            out_short_seen <= hit ? short_fail : ~out_short_seen;
    end
endmodule : aps_power_stage

/* File: dv/tb_auxiliary_protection_supervisor.sv */
// Purpose: self-checking bench for the protection supervisor
// Assumes: TICK_LEN of 10 so one second is 1000 cycles
// Notes: outputs are judged through the live register, read back over the bus; irq and sensor are sampled directly
`timescale 1ns/10ps
module tb_auxiliary_protection_supervisor
    import aps_pkg::*;
;
    logic        clk_sys, srst, avs_read, avs_write, avs_waitrequest, irq, run_cmd;
    logic        dc_brake_active, pre_excite_active, out_phase_missing, out_short_seen;
    logic        out_short_valid, fan_short_seen, supply_short_seen, sync_machine;
    logic        rotor_turning, fault_reset, out_gnd_test_req, sensor, short_fail, slow;
    logic [13:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] ripple, module_temp, hs_temp;
    logic [11:0] qi[$];
    logic [31:0] qm[$], qe[$];
    int          errors, samples_checked;
    localparam logic [15:0] RV [7] = '{RST_PHASE_SEL, RST_IN_THRESH, RST_GND_SEL, RST_FAN_POL,
                                       RST_FAN_DELAY, RST_HS_LEVEL, RST_SENS_SEL};

    aps_supervisor #(.TICK_LEN(10)) aps_supervisor_inst (
        .clk_sys(clk_sys), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .run_cmd(run_cmd),
        .dc_brake_active(dc_brake_active), .pre_excite_active(pre_excite_active),
        .out_phase_missing(out_phase_missing), .in_bus_ripple_pct(ripple),
        .out_short_seen(out_short_seen), .out_short_valid(out_short_valid),
        .fan_short_seen(fan_short_seen), .supply_short_seen(supply_short_seen),
        .sync_machine(sync_machine), .rotor_turning(rotor_turning), .module_temp(module_temp),
        .heatsink_temperature_monitor(hs_temp), .fault_reset(fault_reset),
        .out_gnd_test_req(out_gnd_test_req), .run_enable(), .coast_stop(), .fan_on(),
        .output_phase_loss_fault(), .input_phase_loss_warning(), .input_phase_loss_fault(),
        .output_ground_short_fault(), .fan_ground_short_fault(), .supply_ground_short_fault(),
        .heatsink_overheat_warning(), .platinum_resistance_sensor(sensor));

    aps_power_stage aps_power_stage_inst (
        .clk_sys(clk_sys), .srst(srst), .out_gnd_test_req(out_gnd_test_req),
        .short_fail(short_fail), .slow(slow), .out_short_valid(out_short_valid),
        .out_short_seen(out_short_seen));

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : cmp

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // request held until waitrequest is sampled low, then one idle cycle
    task automatic acc(input logic w, input logic [11:0] i, input logic [15:0] d);
        avs_address   <= {i, 2'b00};
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= {16'h0000, d};
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask : acc

    task automatic wr(input logic [11:0] i, input logic [15:0] d);
        acc(1'b1, i, d);
    endtask : wr

    task automatic rd(input logic [11:0] i, input logic [31:0] m, input logic [31:0] e);
        qi.push_back(i);
        qm.push_back(m);
        qe.push_back(e);
        acc(1'b0, i, 16'h0000);
    endtask : rd

    // events removed first, else a same-cycle event would win over the reset
    task automatic clr;
        out_phase_missing <= 1'b0;
        fan_short_seen    <= 1'b0;
        supply_short_seen <= 1'b0;
        ripple            <= 16'h0000;
        cyc(2);
        fault_reset <= 1'b1;
        cyc(1);
        fault_reset <= 1'b0;
        wr(IDX_IRQ_CLR, 16'h007f);
    endtask : clr

    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    always @(posedge clk_sys) begin
        if (avs_read && avs_waitrequest === 1'b0)
            cmp($sformatf("reg %h", qi.pop_front()), qe.pop_front(),
                avs_readdata & qm.pop_front());
    end

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        cyc(60000);
        errors++;
        results();
    end

    initial begin
        {avs_read, avs_write, run_cmd, dc_brake_active, pre_excite_active} <= 5'h00;
        {out_phase_missing, fan_short_seen, supply_short_seen, sync_machine} <= 4'h0;
        {rotor_turning, fault_reset, short_fail, slow} <= 4'h0;
        {avs_address, avs_writedata} <= 46'h0;
        {ripple, module_temp, hs_temp} <= 48'h0;
        srst <= 1'b1;
        cyc(12);
        srst <= 1'b0;
        cyc(1);
        void'($urandom(76948));
        for (int k = 0; k < 7; k++)
            rd(IDX_PHASE_SEL + 12'(k), 32'hffff, {16'h0000, RV[k]});
        rd(IDX_IRQ_CLR, 32'hffffffff, 32'h0);
        rd(12'ha20, 32'hffffffff, 32'h0);
        cmp("sensor", 32'h0, {31'h0, sensor});
        cyc(40);
        rd(IDX_LIVE, 32'h108, 32'h0);
        wr(IDX_IRQ_EN, 16'h007f);
        out_phase_missing <= 1'b1;
        cyc(3);
        rd(IDX_LIVE, 32'h81, 32'h81);
        cmp("irq", 32'h1, {31'h0, irq});
        clr();
        rd(IDX_IRQ_STAT, 32'h7f, 32'h0);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(IDX_IRQ_EN, 16'h0000);
        out_phase_missing <= 1'b1;
        cyc(3);
        cmp("irq", 32'h0, {31'h0, irq});
        clr();
        wr(IDX_IRQ_EN, 16'h007f);
        wr(IDX_PHASE_SEL, 16'h0020);
        out_phase_missing <= 1'b1;
        cyc(3);
        rd(IDX_LIVE, 32'h1, 32'h0);
        for (int k = 0; k < 2; k++) begin
            dc_brake_active   <= (k == 0);
            pre_excite_active <= (k == 1);
            out_phase_missing <= 1'b1;
            cyc(3);
            rd(IDX_LIVE, 32'h1, 32'h1);
            {dc_brake_active, pre_excite_active} <= 2'b00;
            clr();
        end
        wr(IDX_IN_THRESH, 16'h03e8);
        rd(IDX_IN_THRESH, 32'hffff, 32'h012c);
        wr(IDX_IN_THRESH, RST_IN_THRESH);
        for (int m = 0; m < 3; m++) begin
            wr(IDX_PHASE_SEL, 16'h0001 | 16'(m << 4));
            ripple <= 16'h0065 + 16'($urandom % 200);
            cyc(4);
            rd(IDX_LIVE, 32'h86, m == 1 ? 32'h2 : (m == 2 ? 32'h84 : 32'h0));
            clr();
        end
        ripple <= RST_IN_THRESH;
        cyc(3);
        rd(IDX_LIVE, 32'h6, 32'h0);
        clr();
        for (int f = 0; f < 2; f++) begin
            wr(IDX_GND_SEL, f == 1 ? 16'h0110 : 16'h0000);
            {fan_short_seen, supply_short_seen} <= 2'b11;
            cyc(3);
            rd(IDX_LIVE, 32'h30, f == 1 ? 32'h30 : 32'h0);
            clr();
        end
        hs_temp <= 16'h0321;
        cyc(3);
        rd(IDX_LIVE, 32'h40, 32'h40);
        hs_temp <= 16'h0320;
        cyc(3);
        rd(IDX_LIVE, 32'h40, 32'h0);
        wr(IDX_SENS_SEL, 16'h0000);
        cyc(2);
        cmp("sensor", 32'h1, {31'h0, sensor});
        wr(IDX_GND_SEL, 16'h0002);
        {sync_machine, rotor_turning, run_cmd} <= 3'b111;
        cyc(40);
        rd(IDX_LIVE, 32'h108, 32'h0);
        {rotor_turning, run_cmd} <= 2'b00;
        cyc(3);
        {run_cmd, slow} <= 2'b11;
        cyc(40);
        rd(IDX_LIVE, 32'h108, 32'h100);
        {run_cmd, short_fail} <= 2'b01;
        cyc(3);
        run_cmd <= 1'b1;
        cyc(40);
        rd(IDX_LIVE, 32'h108, 32'h8);
        {run_cmd, short_fail} <= 2'b00;
        clr();
        wr(IDX_GND_SEL, 16'h0000);
        wr(IDX_FAN_POL, 16'h0000);
        cyc(3);
        rd(IDX_LIVE, 32'h200, 32'h200);
        wr(IDX_FAN_DELAY, 16'h1771);
        rd(IDX_FAN_DELAY, 32'hffff, 32'h1770);
        wr(IDX_FAN_DELAY, 16'h0005);
        wr(IDX_FAN_POL, 16'h0002);
        {module_temp, run_cmd} <= {16'h01f5, 1'b1};
        cyc(3);
        rd(IDX_LIVE, 32'h200, 32'h200);
        run_cmd <= 1'b0;
        cyc(20);
        rd(IDX_LIVE, 32'h200, 32'h200);
        cyc(60);
        rd(IDX_LIVE, 32'h200, 32'h0);
        {module_temp, run_cmd} <= {16'h01f4, 1'b1};
        cyc(40);
        rd(IDX_LIVE, 32'h200, 32'h0);
        run_cmd <= 1'b0;
        wr(IDX_FAN_POL, 16'h0001);
        run_cmd <= 1'b1;
        cyc(500);
        rd(IDX_LIVE, 32'h200, 32'h0);
        cyc(600);
        rd(IDX_LIVE, 32'h200, 32'h200);
        {module_temp, run_cmd} <= {16'h01f5, 1'b0};
        cyc(100);
        rd(IDX_LIVE, 32'h200, 32'h200);
        module_temp <= 16'h01f4;
        cyc(29000);
        rd(IDX_LIVE, 32'h200, 32'h200);
        cyc(1600);
        rd(IDX_LIVE, 32'h200, 32'h0);
        cyc(2);
        results();
    end
endmodule : tb_auxiliary_protection_supervisor
